// >>> scmc_ctrl.sv
// self-tune sequencing, conversion mode and hardware averaging control with wishbone registers
//
// Summary of operation
// - setting cal start bit launches self-tune; bit reads 1 until sequence ends
// - setting cal start bit aborts any conversion in progress at once
// - trigger select high, register write or stop mode during self-tune sets fail
// - writing 1 to fail flag bit 6 clears it
// - fail flag reads 0 after clean self-tune, 1 after failed one
// - control bits 5 and 4 always read zero
// - repeat bit clear: one conversion or one averaged set per initiation
// - repeat bit set: conversions or averaged sets repeat after initiation
// - mean enable bit 2 turns hardware averaging off or on
// - count select 00,01,10,11 averages 4,8,16,32 conversions
//
// The placing of the registers and the Wishbone slave port were left to the implementer.
`timescale 1ns/10ps
`default_nettype none

module scmc_ctrl
  import scmc_pkg::*;
#(
  parameter int DATA_W = 16
) (
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone classic slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // converter-side signals, same clock domain
  input wire logic hw_trigger_select_i,
  input wire logic other_reg_write_i,
  input wire logic stop_mode_i,
  input wire logic conv_initiate_i,
  output logic conv_abort_o,
  output logic conv_go_o,
  input wire logic conv_done_i,
  input wire logic [DATA_W-1:0] conv_data_i,
  output logic cal_go_o,
  output logic cal_abort_o,
  input wire logic cal_done_i,
  output logic [DATA_W-1:0] result_o,
  output logic result_valid_o,
  output logic irq_o
);

  // five guard bits hold a full set of 32 samples without overflow
  localparam int ACC_W = DATA_W + SCMC_ACC_EXTRA;

  ////////////////////////////////////////////////////////////////////////////
  // decode helpers

  // right shift that divides the sum by the selected count
  function automatic logic [2:0] mean_shift(input logic [1:0] sel);
    case (sel)
      SCMC_CNT_4: mean_shift = 3'h2;
      SCMC_CNT_8: mean_shift = 3'h3;
      SCMC_CNT_16: mean_shift = 3'h4;
      default: mean_shift = 3'h5;
    endcase
  endfunction : mean_shift

  // index of the last sample of a set
  function automatic logic [4:0] mean_last(input logic [1:0] sel);
    mean_last = 5'((6'h01 << mean_shift(sel)) - 6'h01);
  endfunction : mean_last

  ////////////////////////////////////////////////////////////////////////////
  // state

  scmc_ctrl_s ctrl_q;
  scmc_ctrl_s ctrl_d;
  logic [SCMC_IRQ_W-1:0] irq_stat_q;
  logic [SCMC_IRQ_W-1:0] irq_stat_d;
  logic [SCMC_IRQ_W-1:0] irq_mask_q;
  scmc_state_e state_q;
  scmc_state_e state_d;
  logic [ACC_W-1:0] acc_q;
  logic [4:0] sample_cnt_q;
  logic [DATA_W-1:0] result_q;
  logic result_valid_q;
  logic ack_q;
  logic [31:0] rdata_q;
  logic irq_q;

  ////////////////////////////////////////////////////////////////////////////
  // wishbone decode

  // ack is registered, so every access spans two edges; a request held past ack is taken again
  wire logic req_new = wb_cyc_i & wb_stb_i & ~ack_q;
  // writes land on the edge where ack is seen high
  wire logic wr_fire = wb_cyc_i & wb_stb_i & ack_q & wb_we_i;
  wire logic wr_lane0 = wr_fire & wb_sel_i[0];
  wire logic wr_ctrl = wr_lane0 & (wb_adr_i == SCMC_OFF_CTRL);
  wire logic wr_stat = wr_lane0 & (wb_adr_i == SCMC_OFF_IRQ_STAT);
  wire logic wr_mask = wr_lane0 & (wb_adr_i == SCMC_OFF_IRQ_MASK);
  wire scmc_ctrl_s wr_ctrl_val = scmc_ctrl_s'(wb_dat_i[7:0]);

  wire logic cal_busy = (state_q == SCMC_ST_CAL_REQ) | (state_q == SCMC_ST_CAL_WAIT);
  wire logic conv_busy = (state_q == SCMC_ST_CONV_REQ) | (state_q == SCMC_ST_CONV_WAIT);
  wire logic cal_start = wr_ctrl & wr_ctrl_val.cal & ~cal_busy;
  // the write that starts self-tune is not itself a disturbing write
  wire logic cal_disturb = cal_busy & (hw_trigger_select_i | other_reg_write_i | stop_mode_i | wr_fire);
  wire logic cal_finish = (state_q == SCMC_ST_CAL_WAIT) & cal_done_i;
  wire logic fail_clr = wr_ctrl & wr_ctrl_val.fail;

  ////////////////////////////////////////////////////////////////////////////
  // conversion and averaging datapath

  // a done pulse in the cycle of a self-tune start belongs to the aborted conversion and is dropped
  wire logic conv_take = (state_q == SCMC_ST_CONV_WAIT) & conv_done_i & ~cal_start;
  wire logic [ACC_W-1:0] acc_sum = acc_q + ACC_W'(conv_data_i);
  wire logic set_last = sample_cnt_q == mean_last(ctrl_q.cnt_sel);
  wire logic [ACC_W-1:0] acc_avg = acc_sum >> mean_shift(ctrl_q.cnt_sel);
  wire logic set_done = conv_take & (~ctrl_q.mean_en | set_last);
  // truncating average: low bits of the sum are dropped, no rounding
  wire logic [DATA_W-1:0] set_value = ctrl_q.mean_en ? acc_avg[DATA_W-1:0] : conv_data_i;

  // idle and self-tune clear the sum so a set cut short never leaks into the next one
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      acc_q <= '0;
      sample_cnt_q <= 5'h00;
    end else if (cal_start | (state_q == SCMC_ST_IDLE) | set_done) begin
      acc_q <= '0;
      sample_cnt_q <= 5'h00;
    end else if (conv_take) begin
      acc_q <= acc_sum;
      sample_cnt_q <= sample_cnt_q + 5'h01;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      result_q <= '0;
      result_valid_q <= 1'b0;
    end else begin
      result_valid_q <= set_done;
      if (set_done) begin
        result_q <= set_value;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sequencer

  // a self-tune start overrides every other transition, so the abort needs no state of its own
  always_comb begin
    state_d = state_q;
    case (state_q)
      SCMC_ST_IDLE: begin
        if (conv_initiate_i) begin
          state_d = SCMC_ST_CONV_REQ;
        end
      end
      SCMC_ST_CONV_REQ: begin
        state_d = SCMC_ST_CONV_WAIT;
      end
      SCMC_ST_CONV_WAIT: begin
        if (set_done & ~ctrl_q.repeat_en) begin
          state_d = SCMC_ST_IDLE;
        end else if (conv_take) begin
          state_d = SCMC_ST_CONV_REQ;
        end
      end
      SCMC_ST_CAL_REQ: begin
        state_d = SCMC_ST_CAL_WAIT;
      end
      SCMC_ST_CAL_WAIT: begin
        if (cal_done_i) begin
          state_d = SCMC_ST_IDLE;
        end
      end
      default: begin
        state_d = SCMC_ST_IDLE;
      end
    endcase
    if (cal_start) begin
      state_d = SCMC_ST_CAL_REQ;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q <= SCMC_ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // control register

  // a write while self-tune runs still updates the mode fields; it only marks the run as failed
  always_comb begin
    ctrl_d = ctrl_q;
    if (wr_ctrl) begin
      ctrl_d.repeat_en = wr_ctrl_val.repeat_en;
      ctrl_d.mean_en = wr_ctrl_val.mean_en;
      ctrl_d.cnt_sel = wr_ctrl_val.cnt_sel;
    end
    if (cal_start) begin
      ctrl_d.cal = 1'b1;
    end else if (cal_finish) begin
      ctrl_d.cal = 1'b0;
    end
    // a fresh sequence starts with a clean fail flag so a good run reads 0
    if (cal_start) begin
      ctrl_d.fail = 1'b0;
    end else if (fail_clr) begin
      ctrl_d.fail = 1'b0;
    end
    if (cal_disturb) begin
      ctrl_d.fail = 1'b1;
    end
    ctrl_d.rsvd = 2'h0;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_q <= scmc_ctrl_s'(SCMC_CTRL_RST);
    end else begin
      ctrl_q <= ctrl_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupt status and mask

  // the failure event fires once per run, on the first disturbance only
  logic [SCMC_IRQ_W-1:0] irq_evt;
  assign irq_evt[SCMC_IRQ_CAL_DONE] = cal_finish;
  assign irq_evt[SCMC_IRQ_CAL_FAIL] = cal_disturb & ~ctrl_q.fail;
  assign irq_evt[SCMC_IRQ_RESULT] = set_done;

  // a new event in the clearing cycle survives the write-one-to-clear
  wire logic [SCMC_IRQ_W-1:0] stat_clr = wr_stat ? wb_dat_i[SCMC_IRQ_W-1:0] : '0;
  assign irq_stat_d = (irq_stat_q & ~stat_clr) | irq_evt;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_stat_q <= SCMC_IRQ_RST;
      irq_mask_q <= SCMC_IRQ_RST;
      irq_q <= 1'b0;
    end else begin
      irq_stat_q <= irq_stat_d;
      // a mask write counts at once so the pin never lags the registers by a cycle
      irq_q <= |(irq_stat_d & (wr_mask ? wb_dat_i[SCMC_IRQ_W-1:0] : irq_mask_q));
      if (wr_mask) begin
        irq_mask_q <= wb_dat_i[SCMC_IRQ_W-1:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read path and ack

  // read data is captured when the request is taken and held until the next one
  logic [31:0] rd_mux;
  always_comb begin
    case (wb_adr_i)
      SCMC_OFF_CTRL: rd_mux = {24'h000000, ctrl_q};
      SCMC_OFF_IRQ_STAT: rd_mux = {29'h00000000, irq_stat_q};
      SCMC_OFF_IRQ_MASK: rd_mux = {29'h00000000, irq_mask_q};
      SCMC_OFF_RESULT: rd_mux = 32'(result_q);
      default: rd_mux = 32'h00000000;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
      rdata_q <= 32'h00000000;
    end else begin
      ack_q <= req_new;
      if (req_new) begin
        rdata_q <= rd_mux;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  // handshake and data outputs other than the abort come straight from flip-flops or the state register
  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdata_q;
  // the abort is combinational so the converter stops in the very cycle the start lands
  assign conv_abort_o = cal_start & conv_busy;
  assign conv_go_o = state_q == SCMC_ST_CONV_REQ;
  assign cal_go_o = state_q == SCMC_ST_CAL_REQ;
  // aborting self-tune is not offered; a disturbed run still ends on its own
  assign cal_abort_o = 1'b0;
  assign result_o = result_q;
  assign result_valid_o = result_valid_q;
  assign irq_o = irq_q;

endmodule : scmc_ctrl

`default_nettype wire

// >>> scmc_ctrl_sva.sv
// assertion checker for the self-tune and averaging control block
`timescale 1ns/10ps
`default_nettype none
module scmc_ctrl_sva
  import scmc_pkg::*;
#(
  parameter int DATA_W = 16
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic hw_trigger_select_i,
  input wire logic other_reg_write_i,
  input wire logic stop_mode_i,
  input wire logic conv_initiate_i,
  input wire logic conv_abort_o,
  input wire logic conv_go_o,
  input wire logic conv_done_i,
  input wire logic [DATA_W-1:0] conv_data_i,
  input wire logic cal_go_o,
  input wire logic cal_abort_o,
  input wire logic cal_done_i,
  input wire logic [DATA_W-1:0] result_o,
  input wire logic result_valid_o,
  input wire logic irq_o
);
  logic run_q, busy_q;
  logic [3:0] mode_q;
  logic [6:0] n_q;
  wire logic wr_c = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o & wb_sel_i[0] & (wb_adr_i == SCMC_OFF_CTRL);
  ////////////////////////////////////////
  // own shadow of the mode bits, so a stuck design copy cannot hide itself
  always_ff @(posedge clk_i) run_q <= ~rst_i & (cal_go_o | (run_q & ~cal_done_i));
  always_ff @(posedge clk_i) busy_q <= ~rst_i & (conv_go_o | (busy_q & ~conv_done_i & ~conv_abort_o));
  always_ff @(posedge clk_i) mode_q <= rst_i ? 4'h0 : (wr_c ? wb_dat_i[3:0] : mode_q);
  always_ff @(posedge clk_i) n_q <= (rst_i | result_valid_o | cal_go_o) ? 7'h00 : n_q + 7'(conv_done_i & busy_q);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  property p_cal_go; wr_c && wb_dat_i[SCMC_BIT_CAL] && !run_q && !cal_go_o |=> cal_go_o; endproperty
  a_cal_go: assert property (p_cal_go) else $error("self-tune not started");
  property p_abort; wr_c && wb_dat_i[SCMC_BIT_CAL] && busy_q && !run_q |-> conv_abort_o; endproperty
  a_abort: assert property (p_abort) else $error("conversion not aborted");
  property p_rsvd; wb_ack_o && !wb_we_i && wb_adr_i == SCMC_OFF_CTRL |-> wb_dat_o[5:4] == 2'h0; endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved bits nonzero");
  property p_single; conv_done_i && busy_q && mode_q[3:2] == 2'h0 |=> !conv_go_o; endproperty
  a_single: assert property (p_single) else $error("extra conversion");
  property p_repeat; conv_done_i && busy_q && mode_q[3] && !wr_c |=> conv_go_o; endproperty
  a_repeat: assert property (p_repeat) else $error("repeat stopped");
  property p_plain; conv_done_i && busy_q && !mode_q[2] && !wr_c |=> result_valid_o && result_o == $past(conv_data_i);
  endproperty
  a_plain: assert property (p_plain) else $error("plain result wrong");
  property p_count; result_valid_o && mode_q[2] |-> n_q == (7'h04 << mode_q[1:0]); endproperty
  a_count: assert property (p_count) else $error("wrong sample count");
  property p_once; result_valid_o |-> $past(conv_done_i); endproperty
  a_once: assert property (p_once) else $error("stray result");
  c_cal: cover property (cal_go_o);
  c_abort: cover property (conv_abort_o);
  c_mean32: cover property (result_valid_o && mode_q == 4'h7);
endmodule : scmc_ctrl_sva
bind scmc_ctrl scmc_ctrl_sva #(.DATA_W(DATA_W)) scmc_ctrl_sva_inst (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
  .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .hw_trigger_select_i, .other_reg_write_i, .stop_mode_i,
  .conv_initiate_i, .conv_abort_o, .conv_go_o, .conv_done_i, .conv_data_i, .cal_go_o, .cal_abort_o, .cal_done_i,
  .result_o, .result_valid_o, .irq_o);
`default_nettype wire

// >>> scmc_ctrl_tb.sv
// self-checking bench for the self-tune and averaging control block
`timescale 1ns/10ps
`default_nettype none
module testbench
  import scmc_pkg::*;
;
  logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, hw_trigger_select_i, other_reg_write_i, stop_mode_i;
  logic conv_initiate_i, conv_done_i, cal_done_i, wb_ack_o, conv_abort_o, conv_go_o, cal_go_o, cal_abort_o;
  logic result_valid_o, irq_o;
  logic [3:0] wb_adr_i, wb_sel_i, bsel;
  logic [31:0] wb_dat_i, wb_dat_o, rd;
  logic [15:0] conv_data_i, result_o;
  int fails, checks, ngo, nval, nab;
  scmc_ctrl #(.DATA_W(16)) scmc_ctrl_inst (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
    .wb_dat_i, .wb_dat_o, .wb_ack_o, .hw_trigger_select_i, .other_reg_write_i, .stop_mode_i, .conv_initiate_i,
    .conv_abort_o, .conv_go_o, .conv_done_i, .conv_data_i, .cal_go_o, .cal_abort_o, .cal_done_i, .result_o,
    .result_valid_o, .irq_o);
  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    if (conv_go_o === 1'b1) ngo <= ngo + 1;
    if (result_valid_o === 1'b1) nval <= nval + 1;
    if (conv_abort_o === 1'b1) nab <= nab + 1;
  end
  ////////////////////////////////////////
  task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
    checks++;
    if (g !== e) begin
      fails++;
      $display("unexpected at %0t: %s got %0h", $time, m, g);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask : tick
  // holds the request until ack is sampled, then releases for at least a cycle
  task wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    tick(1);
    {wb_cyc_i, wb_stb_i, wb_we_i} <= {2'h3, w};
    {wb_adr_i, wb_sel_i, wb_dat_i} <= {a, bsel, d};
    do begin
      tick(1);
      n++;
    end while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    {wb_cyc_i, wb_stb_i} <= 2'h0;
    chk(n, 2, "ack latency");
  endtask : wb
  task wgo;
    int n;
    n = 0;
    do begin
      tick(1);
      n++;
    end while (conv_go_o !== 1'b1 && n < 50);
    chk(n < 50, 1, "no start");
  endtask : wgo
  // released data line shows the inverse, never a stale copy
  task serve(input logic [15:0] d);
    wgo();
    tick(1);
    {conv_done_i, conv_data_i} <= {1'b1, d};
    tick(1);
    {conv_done_i, conv_data_i} <= {1'b0, ~d};
  endtask : serve
  task pulse_init;
    tick(1);
    conv_initiate_i <= 1'b1;
    tick(1);
    conv_initiate_i <= 1'b0;
  endtask : pulse_init
  task cal_end;
    tick(1);
    cal_done_i <= 1'b1;
    tick(1);
    cal_done_i <= 1'b0;
    tick(2);
  endtask : cal_end
  task summarize;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : summarize
  ////////////////////////////////////////
  task t_regs;
    bsel = 4'hE;
    wb(1'b1, SCMC_OFF_CTRL, 32'h0C);
    bsel = 4'hF;
    wb(1'b0, SCMC_OFF_CTRL, 32'h0);
    chk(rd, 32'h0, "sel ignored");
    wb(1'b1, SCMC_OFF_CTRL, 32'hFFFFFF3F);
    wb(1'b0, SCMC_OFF_CTRL, 32'h0);
    chk(rd, 32'h0F, "ctrl");
    wb(1'b0, 4'h2, 32'h0);
    chk(rd, 32'h0, "unmapped");
    wb(1'b1, SCMC_OFF_CTRL, 32'h0);
  endtask : t_regs
  task t_conv;
    int g, v;
    logic [20:0] sum;
    logic [15:0] d;
    for (int s = -1; s < 4; s++) begin
      wb(1'b1, SCMC_OFF_CTRL, (s < 0) ? 32'h0 : 32'h4 | s);
      {g, v, sum} = {ngo, nval, 21'h0};
      pulse_init();
      for (int k = 0; k < ((s < 0) ? 1 : (4 << s)); k++) begin
        d = 16'hF0F0 - 16'(k * 397 + s * 11);
        sum += 21'(d);
        serve(d);
      end
      tick(4);
      chk(nval - v, 1, "sets");
      chk(ngo - g, (s < 0) ? 1 : (4 << s), "samples");
      chk(result_o, 16'(sum >> ((s < 0) ? 0 : s + 2)), "mean");
    end
  endtask : t_conv
  task t_rep;
    int v, a;
    wb(1'b1, SCMC_OFF_CTRL, 32'h8);
    v = nval;
    pulse_init();
    for (int k = 0; k < 3; k++) serve(16'(k + 1));
    wgo();
    a = nab;
    wb(1'b1, SCMC_OFF_CTRL, 32'h88);
    tick(2);
    chk(nab - a, 1, "abort");
    chk(nval - v, 3, "repeat");
    cal_end();
    wb(1'b0, SCMC_OFF_CTRL, 32'h0);
    chk(rd, 32'h8, "cal end");
    wb(1'b1, SCMC_OFF_CTRL, 32'h0);
  endtask : t_rep
  task t_fail;
    for (int i = 0; i < 5; i++) begin
      wb(1'b1, SCMC_OFF_CTRL, 32'h80);
      wb(1'b0, SCMC_OFF_CTRL, 32'h0);
      chk(rd[7], 1'b1, "cal bit");
      chk(cal_abort_o, 1'b0, "self-tune abort");
      tick(1);
      hw_trigger_select_i <= (i == 0);
      stop_mode_i <= (i == 1);
      other_reg_write_i <= (i == 2);
      tick(1);
      {hw_trigger_select_i, stop_mode_i, other_reg_write_i} <= 3'h0;
      if (i == 3) wb(1'b1, SCMC_OFF_IRQ_MASK, 32'h0);
      cal_end();
      wb(1'b0, SCMC_OFF_CTRL, 32'h0);
      chk(rd[7:6], {1'b0, i < 4}, "fail flag");
      wb(1'b1, SCMC_OFF_CTRL, 32'h40);
      wb(1'b0, SCMC_OFF_CTRL, 32'h0);
      chk(rd[6], 1'b0, "flag clear");
    end
  endtask : t_fail
  task t_irq;
    wb(1'b0, SCMC_OFF_IRQ_STAT, 32'h0);
    chk(rd, 32'h7, "status");
    chk(irq_o, 1'b0, "masked irq");
    wb(1'b1, SCMC_OFF_IRQ_MASK, 32'h2);
    tick(2);
    chk(irq_o, 1'b1, "irq");
    wb(1'b1, SCMC_OFF_IRQ_STAT, 32'h7);
    tick(2);
    chk(irq_o, 1'b0, "irq clear");
  endtask : t_irq
  ////////////////////////////////////////
  initial begin
    rst_i = 1'b1;
    bsel = 4'hF;
    {wb_cyc_i, wb_stb_i, wb_we_i, hw_trigger_select_i, other_reg_write_i, stop_mode_i} = 6'h00;
    {conv_initiate_i, conv_done_i, cal_done_i, wb_adr_i, wb_sel_i, wb_dat_i, conv_data_i} = '0;
    tick(16);
    rst_i <= 1'b0;
    t_regs();
    t_conv();
    t_rep();
    t_fail();
    t_irq();
    summarize();
  end
  initial begin
    repeat (20000) @(posedge clk_i);
    fails++;
    summarize();
  end
endmodule : testbench
`default_nettype wire

// >>> scmc_pkg.sv
// shared constants and types for the self-tune and averaging control block
package scmc_pkg;

  // register byte offsets on the wishbone bus
  localparam logic [3:0] SCMC_OFF_CTRL = 4'h0;
  localparam logic [3:0] SCMC_OFF_IRQ_STAT = 4'h4;
  localparam logic [3:0] SCMC_OFF_IRQ_MASK = 4'h8;
  localparam logic [3:0] SCMC_OFF_RESULT = 4'hC;

  // control register field positions
  localparam int SCMC_BIT_CAL = 7;
  localparam int SCMC_BIT_FAIL = 6;
  localparam int SCMC_BIT_REPEAT = 3;
  localparam int SCMC_BIT_MEAN_EN = 2;
  localparam int SCMC_LSB_CNT_SEL = 0;

  // interrupt status and mask bit positions
  localparam int SCMC_IRQ_CAL_DONE = 0;
  localparam int SCMC_IRQ_CAL_FAIL = 1;
  localparam int SCMC_IRQ_RESULT = 2;
  localparam int SCMC_IRQ_W = 3;

  // reset values
  localparam logic [7:0] SCMC_CTRL_RST = 8'h00;
  localparam logic [2:0] SCMC_IRQ_RST = 3'h0;

  // mean count select encodings
  localparam logic [1:0] SCMC_CNT_4 = 2'h0;
  localparam logic [1:0] SCMC_CNT_8 = 2'h1;
  localparam logic [1:0] SCMC_CNT_16 = 2'h2;
  localparam logic [1:0] SCMC_CNT_32 = 2'h3;

  // widest average needs five extra accumulator bits
  localparam int SCMC_ACC_EXTRA = 5;

  typedef struct packed {
    logic cal;
    logic fail;
    logic [1:0] rsvd;
    logic repeat_en;
    logic mean_en;
    logic [1:0] cnt_sel;
  } scmc_ctrl_s;

  typedef enum logic [2:0] {
    SCMC_ST_IDLE,
    SCMC_ST_CONV_REQ,
    SCMC_ST_CONV_WAIT,
    SCMC_ST_CAL_REQ,
    SCMC_ST_CAL_WAIT
  } scmc_state_e;

endpackage : scmc_pkg
